// file: src/clk_ctl_pkg.sv
/*
  Shared constants and carrier types for the clock multiplier configuration,
  lock detector and converter calibration control block.
  Assumes a 32-bit APB register port and a single 40 MHz system clock.
*/
package clk_ctl_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_LOOP = 6'h02;
  localparam logic [5:0] IDX_CALAUX = 6'h03;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h04;
  localparam logic [5:0] IDX_IRQ_EN = 6'h05;
  localparam logic [5:0] IDX_IRQ_CLR = 6'h06;
  localparam int ADDR_W = 8;

  // Field positions inside the status word
  localparam int LOCK_BIT = 24;
  localparam int BUSY_BIT = 0;

  // Writable bits and reset values
  localparam logic [31:0] LOOP_WMASK = 32'h0009_ff7f;
  localparam logic [31:0] LOOP_RESET = 32'h0000_1900;
  localparam logic [31:0] CALAUX_WMASK = 32'h06ff_ffff;
  localparam logic [31:0] CALAUX_RESET = 32'h0000_0000;
  localparam logic [7:0] FB_N_RESET = 8'h19;

  // Interrupt event bit positions
  localparam int IRQ_W = 3;
  localparam int EV_LOCK_GAIN = 0;
  localparam int EV_LOCK_LOSS = 1;
  localparam int EV_CAL_DONE = 2;

  // Timing counts
  localparam int LOCK_CNT_W = 11;
  localparam logic [LOCK_CNT_W-1:0] LOCK_BASE_CYCLES = 11'h080;
  localparam logic [7:0] CAL_CYCLES = 8'h40;

  typedef struct packed {
    logic [11:0] open_hi;
    logic dbl_en;
    logic [1:0] pll_other;
    logic dbl_sel;
    logic [7:0] fb_n;
    logic open7;
    logic icp_manual;
    logic [2:0] icp_code;
    logic ld_en;
    logic [1:0] ldw_sel;
  } loop_cfg_type;

  typedef struct packed {
    logic [4:0] open_hi;
    logic aux_pd;
    logic calclk_pd;
    logic cal_en;
    logic [23:0] low_bits;
  } cal_ctl_type;

  typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_type;

  // Lock window length in reference cycles: 128, 256, 512 or 1024
  function automatic logic [LOCK_CNT_W-1:0] lock_limit(input logic [1:0] sel);
    lock_limit = LOCK_BASE_CYCLES << sel;
  endfunction : lock_limit

endpackage : clk_ctl_pkg

// file: src/lock_detect.sv
/*
  Lock detector: counts reference clock edges while the phase error stays
  inside the window. Assumes both pins are asynchronous to clk_sys and the
  reference runs well below half the system clock.
*/
`timescale 1ns/1ps
module lock_detect
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ref_clk_pin,
  input wire logic phase_ok_pin,
  input wire logic enable,
  input wire logic [1:0] ldw_sel,
  output logic locked
);
  import clk_ctl_pkg::*;

  typedef struct packed {
    logic [1:0] ref_s;
    logic ref_d;
    logic [1:0] ok_s;
    logic [LOCK_CNT_W-1:0] count;
    logic locked;
  } ld_state_type;

  ld_state_type s_r;
  ld_state_type s_nxt;
  logic ref_rise;

  assign ref_rise = s_r.ref_s[1] & ~s_r.ref_d;
  assign locked = s_r.locked;

  // Count qualified reference edges; any excursion starts over
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ref_s = {s_r.ref_s[0], ref_clk_pin};
    s_nxt.ok_s = {s_r.ok_s[0], phase_ok_pin};
    s_nxt.ref_d = s_r.ref_s[1];
    if (!enable || !s_r.ok_s[1])
    begin
      s_nxt.count = '0;
      s_nxt.locked = 1'b0;
    end
    else if (ref_rise && !s_r.locked)
    begin
      s_nxt.count = s_r.count + 11'h001;
      if (s_nxt.count == lock_limit(ldw_sel))
        s_nxt.locked = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  window_count_a: assert property ($rose(s_r.locked) |-> s_r.count == lock_limit(ldw_sel))
    else $error("lock reported before the window count was reached");
  excursion_clear_a: assert property (!s_r.ok_s[1] |=> s_r.count == '0 && !s_r.locked)
    else $error("counter or lock not cleared after phase excursion");
  lock_seen_c: cover property ($rose(s_r.locked));

endmodule : lock_detect

// file: src/cal_sequencer.sv
/*
  Converter calibration sequencer: one start pulse runs a calibration that
  advances only while the calibration clock is enabled.
  Assumes start is a one-cycle pulse from logic on clk_sys.
*/
`timescale 1ns/1ps
module cal_sequencer
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic clk_run,
  output logic busy,
  output logic done
);
  import clk_ctl_pkg::*;

  typedef struct packed {
    cal_state_type state;
    logic [7:0] count;
    logic busy;
    logic done;
  } cal_seq_state_type;

  cal_seq_state_type s_r;
  cal_seq_state_type s_nxt;

  assign busy = s_r.busy;
  assign done = s_r.done;

  // A start during a running calibration is ignored rather than restarting it
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.state)
      CAL_IDLE:
        if (start)
        begin
          s_nxt.state = CAL_RUN;
          s_nxt.count = '0;
          s_nxt.busy = 1'b1;
        end
      CAL_RUN:
        if (clk_run)
        begin
          s_nxt.count = s_r.count + 8'h01;
          if (s_r.count == CAL_CYCLES - 8'h01)
          begin
            s_nxt.state = CAL_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end
        end
      default:
        s_nxt.state = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  stalled_cal_a: assert property (s_r.busy && !clk_run |=> !s_r.done)
    else $error("calibration finished while its clock was stopped");
  cal_done_c: cover property (s_r.done);

endmodule : cal_sequencer

// file: src/clk_ctl_top.sv
/*
  Clock multiplier configuration, lock detection and converter calibration
  control, reached over an APB slave with one wait state per transfer.
  Assumes the reference clock and phase window pins are asynchronous, and
  that software keeps the feedback divider and calibration low bits legal.
  Every output of the block is a register copy, so pins see no decode glitches.
*/
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module clk_ctl_top
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clk_ctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clk_pin,
  input wire logic phase_ok_pin,
  output logic doubler_active,
  output logic [8:0] loop_mult,
  output logic pump_auto,
  output logic [2:0] pump_code,
  output logic lock_det_en,
  output logic locked,
  output logic sync_out_en,
  output logic cal_clk_en,
  output logic cal_busy,
  output logic irq
);
  import clk_ctl_pkg::*;

  typedef struct packed {
    loop_cfg_type loop;
    cal_ctl_type calaux;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic lock_d;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cal_start;
    logic dbl_active;
    logic [8:0] loop_mult;
    logic pump_auto;
    logic [2:0] pump_code;
    logic ld_en;
    logic sync_en;
    logic calclk_en;
    logic irq;
  } top_state_type;

  top_state_type s_r;
  top_state_type s_nxt;
  logic addr_hit;
  logic [31:0] rd_word;
  logic [5:0] idx;
  logic commit;
  logic lock_q;
  logic busy_q;
  logic done_q;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr_bits;
  cal_ctl_type wr_cal;

  // Word index of an aligned address; misaligned addresses never hit
  function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[ADDR_W-1:2];
  endfunction : word_index

  assign idx = word_index(paddr);
  assign commit = psel & penable & s_r.pready & addr_hit & pwrite;
  assign wr_cal = cal_ctl_type'(pwdata);

  // Address decode and read data mux
  always_comb
  begin
    addr_hit = 1'b0;
    rd_word = '0;
    if (paddr[1:0] == 2'b00)
    begin
      case (idx)
        IDX_STATUS:
        begin
          addr_hit = 1'b1;
          rd_word[LOCK_BIT] = lock_q;
          rd_word[BUSY_BIT] = busy_q;
        end
        IDX_LOOP:
        begin
          addr_hit = 1'b1;
          rd_word = s_r.loop;
        end
        IDX_CALAUX:
        begin
          addr_hit = 1'b1;
          rd_word = s_r.calaux;
          // The start bit is write-only; its read position shows the run in progress
          rd_word[LOCK_BIT] = busy_q;
        end
        IDX_IRQ_STAT:
        begin
          addr_hit = 1'b1;
          rd_word[IRQ_W-1:0] = s_r.irq_stat;
        end
        IDX_IRQ_EN:
        begin
          addr_hit = 1'b1;
          rd_word[IRQ_W-1:0] = s_r.irq_en;
        end
        IDX_IRQ_CLR:
          addr_hit = 1'b1;
        default:
          addr_hit = 1'b0;
      endcase
    end
  end

  // Events from the lock detector edges and the calibration end
  always_comb
  begin
    events = '0;
    events[EV_LOCK_GAIN] = lock_q & ~s_r.lock_d;
    events[EV_LOCK_LOSS] = ~lock_q & s_r.lock_d;
    events[EV_CAL_DONE] = done_q;
    clr_bits = '0;
    if (commit && idx == IDX_IRQ_CLR)
      clr_bits = pwdata[IRQ_W-1:0];
  end

  // Next state: bus answer, register writes, derived controls, interrupt
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cal_start = 1'b0;
    s_nxt.lock_d = lock_q;
    // Access phase gets one wait state so read data comes from a flop
    if (psel && penable && !s_r.pready)
    begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = ~addr_hit;
      s_nxt.prdata = addr_hit ? rd_word : '0;
    end
    else
    begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
    end
    // Writes land only at the completing edge; a refused address never commits
    if (commit)
    begin
      case (idx)
        IDX_LOOP:
          s_nxt.loop = loop_cfg_type'(pwdata & LOOP_WMASK);
        IDX_CALAUX:
        begin
          s_nxt.calaux = cal_ctl_type'(pwdata & CALAUX_WMASK);
          s_nxt.cal_start = wr_cal.cal_en;
        end
        IDX_IRQ_EN:
          s_nxt.irq_en = pwdata[IRQ_W-1:0];
        default:
          s_nxt.cal_start = 1'b0;
      endcase
    end
    // A new event wins over a clear arriving in the same cycle
    s_nxt.irq_stat = (s_r.irq_stat & ~clr_bits) | events;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
    // Controls are taken from the next register value so that they switch at the
    // same edge as the write that changes them, never one cycle behind it
    s_nxt.dbl_active = s_nxt.loop.dbl_en & s_nxt.loop.dbl_sel;
    s_nxt.loop_mult = {s_nxt.loop.fb_n, 1'b0};
    s_nxt.pump_auto = ~s_nxt.loop.icp_manual;
    s_nxt.pump_code = s_nxt.loop.icp_manual ? s_nxt.loop.icp_code : 3'h0;
    s_nxt.ld_en = s_nxt.loop.ld_en;
    s_nxt.sync_en = ~s_nxt.calaux.aux_pd;
    s_nxt.calclk_en = ~s_nxt.calaux.calclk_pd & ~s_nxt.calaux.aux_pd;
  end

  // Reset values mirror the register defaults so outputs agree from reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.loop <= loop_cfg_type'(LOOP_RESET);
      s_r.calaux <= cal_ctl_type'(CALAUX_RESET);
      s_r.loop_mult <= {FB_N_RESET, 1'b0};
      s_r.pump_auto <= 1'b1;
      s_r.sync_en <= 1'b1;
      s_r.calclk_en <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Lock detector on the synchronised reference edges; the raw pins go
  // straight in, since only its two-flop stages may look at them
  lock_detect i_lock_detect
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .ref_clk_pin(ref_clk_pin),
    .phase_ok_pin(phase_ok_pin),
    .enable(s_r.ld_en),
    .ldw_sel(s_r.loop.ldw_sel),
    .locked(lock_q)
  );

  // Calibration only advances while its clock is allowed to run
  cal_sequencer i_cal_sequencer
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(s_r.cal_start),
    .clk_run(s_r.calclk_en),
    .busy(busy_q),
    .done(done_q)
  );

  // Every output is a register copy
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign doubler_active = s_r.dbl_active;
  assign loop_mult = s_r.loop_mult;
  assign pump_auto = s_r.pump_auto;
  assign pump_code = s_r.pump_code;
  assign lock_det_en = s_r.ld_en;
  assign locked = lock_q;
  assign sync_out_en = s_r.sync_en;
  assign cal_clk_en = s_r.calclk_en;
  assign cal_busy = busy_q;
  assign irq = s_r.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Derived outputs against their register fields
  doubler_gate_a: assert property (doubler_active |-> s_r.loop.dbl_en && s_r.loop.dbl_sel)
    else $error("doubler active without both enabling bits");
  doubler_en_a: assert property (!s_r.loop.dbl_sel |-> !doubler_active)
    else $error("doubler active with circuit select clear");
  loop_mult_a: assert property (loop_mult == 9'(2 * int'(s_r.loop.fb_n)))
    else $error("loop multiplier is not twice the feedback value");
  // Reset default, pump mode, lock reporting, power-down gating and the calibration trigger
  reset_mult_a: assert property (@(posedge clk_sys) $fell(rst) |-> loop_mult == 9'd50)
    else $error("default multiplication after reset is not fifty");
  pump_mode_a: assert property (pump_auto == !s_r.loop.icp_manual)
    else $error("pump current mode does not follow the select bit");
  pump_code_a: assert property (pump_auto |-> pump_code == 3'h0)
    else $error("manual pump code applied in automatic mode");
  detect_off_a: assert property (!lock_det_en |=> !locked)
    else $error("lock reported while detection disabled");
  status_lock_a: assert property (psel && penable && !pready && !pwrite
    && paddr == {IDX_STATUS, 2'b00} |=> prdata[LOCK_BIT] == $past(lock_q))
    else $error("status read does not return the lock state");
  sync_out_a: assert property (sync_out_en == !s_r.calaux.aux_pd)
    else $error("sync output enable does not follow the power-down bit");
  cal_clock_a: assert property (cal_clk_en |-> !s_r.calaux.aux_pd && !s_r.calaux.calclk_pd)
    else $error("calibration clock runs while powered down");
  cal_start_a: assert property (commit && idx == IDX_CALAUX && wr_cal.cal_en && !busy_q
    |=> ##1 cal_busy)
    else $error("calibration did not start after the trigger write");

  // Doubler and pump outputs must turn on as well as stay off
  doubler_on_a: assert property (s_r.loop.dbl_en && s_r.loop.dbl_sel |-> doubler_active)
    else $error("doubler idle although both enabling bits are set");
  pump_manual_a: assert property (!pump_auto |-> pump_code == s_r.loop.icp_code)
    else $error("manual pump code not applied in manual mode");

  // Calibration clock gating and a calibration that waits for its clock
  cal_clock_on_a: assert property (!s_r.calaux.aux_pd && !s_r.calaux.calclk_pd
    |-> cal_clk_en)
    else $error("calibration clock stopped with both power-down bits clear");
  cal_hold_a: assert property (cal_busy && !cal_clk_en |=> cal_busy)
    else $error("calibration ended while its clock was stopped");
  cal_once_a: assert property ($rose(cal_busy) |-> $past(s_r.cal_start))
    else $error("calibration started without a trigger write");

  // Lock only with detection on; busy reads back at the trigger position
  lock_needs_en_a: assert property ($rose(locked) |-> $past(lock_det_en))
    else $error("lock reported although detection was off");
  busy_read_a: assert property (psel && penable && !pready && !pwrite
    && paddr == {IDX_CALAUX, 2'b00} |=> prdata[LOCK_BIT] == $past(busy_q))
    else $error("calibration control read does not show the run in progress");

  // One wait state, a one-cycle answer, and refused transfers change nothing
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held for more than one cycle");
  bad_write_a: assert property (pready && pslverr && pwrite
    |=> $stable(s_r.loop) && $stable(s_r.calaux))
    else $error("refused write changed a configuration register");
  read_zero_err_a: assert property (pready && pslverr |-> prdata == '0)
    else $error("refused transfer returned nonzero read data");

  // Accepted writes land under their masks
  loop_write_a: assert property (commit && idx == IDX_LOOP
    |=> s_r.loop == loop_cfg_type'($past(pwdata) & LOOP_WMASK))
    else $error("loop configuration write did not land under its mask");
  calaux_write_a: assert property (commit && idx == IDX_CALAUX
    |=> s_r.calaux == cal_ctl_type'($past(pwdata) & CALAUX_WMASK))
    else $error("calibration control write did not land under its mask");

  // Interrupt status: events land, a clear removes only what it names
  lock_gain_irq_a: assert property ($rose(locked) |=> s_r.irq_stat[EV_LOCK_GAIN])
    else $error("lock gain not recorded in the interrupt status");
  lock_loss_irq_a: assert property ($fell(locked) |=> s_r.irq_stat[EV_LOCK_LOSS])
    else $error("lock loss not recorded in the interrupt status");
  cal_done_irq_a: assert property ($fell(cal_busy) |=> s_r.irq_stat[EV_CAL_DONE])
    else $error("calibration end not recorded in the interrupt status");
  set_wins_a: assert property (events != '0
    |=> (s_r.irq_stat & $past(events)) == $past(events))
    else $error("an interrupt event was lost");
  irq_clear_a: assert property (commit && idx == IDX_IRQ_CLR && events == '0
    |=> (s_r.irq_stat & $past(clr_bits)) == '0)
    else $error("interrupt clear left a named status bit set");
  irq_level_a: assert property (irq == |(s_r.irq_stat & s_r.irq_en))
    else $error("interrupt line does not follow enabled status");

  irq_seen_c: cover property (irq);
  cal_write_c: cover property (commit && idx == IDX_CALAUX && wr_cal.cal_en);
  bad_addr_c: cover property (pready && pslverr);

endmodule : clk_ctl_top

// file: verification/pll_ref_model.sv
/*
  Far-side model of the analogue loop: a free-running reference clock and a
  phase window flag. Assumes clk_sys at 40 MHz and a bench that steers the window.
*/
`timescale 1ns/1ps
module pll_ref_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_window,
  output logic ref_clk_pin,
  output logic phase_ok_pin
);
  logic [1:0] div_r;
  // Reference at clk_sys/8, well inside the block's two-flop sampling limit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      div_r <= 2'h0;
      ref_clk_pin <= 1'b0;
      phase_ok_pin <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3)
        ref_clk_pin <= !ref_clk_pin;
      phase_ok_pin <= in_window;
    end
  end
endmodule : pll_ref_model

// file: verification/clk_ctl_top_tb.sv
/*
  Self-checking bench: APB register traffic, lock detection, calibration, interrupts.
  Assumes the one-wait-state APB slave and the map in the shared package.
*/
`timescale 1ns/1ps
module clk_ctl_top_tb;
  import clk_ctl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic in_window = 1'b0;
  logic [31:0] prdata;
  logic [8:0] loop_mult;
  logic [2:0] pump_code;
  logic pready, pslverr, ref_clk_pin, phase_ok_pin, doubler_active, pump_auto;
  logic lock_det_en, locked, sync_out_en, cal_clk_en, cal_busy, irq;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int compares = 0;

  pll_ref_model i_pll_ref_model (.clk_sys(clk_sys), .rst(rst), .in_window(in_window),
    .ref_clk_pin(ref_clk_pin), .phase_ok_pin(phase_ok_pin));
  clk_ctl_top i_clk_ctl_top (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clk_pin(ref_clk_pin), .phase_ok_pin(phase_ok_pin),
    .doubler_active(doubler_active), .loop_mult(loop_mult), .pump_auto(pump_auto),
    .pump_code(pump_code), .lock_det_en(lock_det_en), .locked(locked),
    .sync_out_en(sync_out_en), .cal_clk_en(cal_clk_en), .cal_busy(cal_busy), .irq(irq));

  // 40 MHz system clock
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; entered just after an edge, leaves one idle edge behind
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // Reset state, writable mask and the feedback multiplier at its upper limit
  task automatic loop_config;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_1900);
    chk({23'h0, loop_mult}, 32'h32);
    chk({27'h0, pump_auto, pump_code, lock_det_en}, 32'h10);
    chk({30'h0, sync_out_en, cal_clk_en}, 32'h3);
    apb(1'b1, 8'h08, 32'hffff_ffff);
    chk({23'h0, loop_mult}, 32'h1fe);
    chk({27'h0, pump_auto, pump_code, lock_det_en}, 32'hf);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0009_ff7f);
    apb(1'b1, 8'h08, 32'h0000_0a00);
    chk({23'h0, loop_mult}, 32'h14);
  endtask : loop_config

  // Doubler needs both bits; pump code only counts in manual mode
  task automatic doubler_pump;
    logic [31:0] dbl [3] = '{32'h0001_0000, 32'h0008_0000, 32'h0009_0000};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h08, 32'h0000_1900 | dbl[i]);
      chk({31'h0, doubler_active}, {31'h0, i == 2});
    end
    apb(1'b1, 8'h08, 32'h0000_1928);
    chk({28'h0, pump_auto, pump_code}, 32'h8);
    apb(1'b1, 8'h08, 32'h0000_1968);
    chk({28'h0, pump_auto, pump_code}, 32'h5);
  endtask : doubler_pump

  // Every window length, a restart in mid-count, loss of lock, detection off
  task automatic lock_window;
    int i;
    in_window <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 8'h08, 32'h0000_1900);
      apb(1'b1, 8'h08, 32'h0000_1904 | 32'(s));
      if (s == 0)
      begin
        repeat (600) @(posedge clk_sys);
        in_window <= 1'b0;
        repeat (10) @(posedge clk_sys);
        in_window <= 1'b1;
      end
      repeat ((1024 << s) - 16) @(posedge clk_sys);
      chk({31'h0, locked}, 32'h0);
      for (i = 0; i < 40 && locked !== 1'b1; i++) @(posedge clk_sys);
      chk({31'h0, locked}, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd & 32'h0100_0000, 32'h0100_0000);
      in_window <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk({31'h0, locked}, 32'h0);
      in_window <= 1'b1;
    end
    apb(1'b1, 8'h08, 32'h0000_1900);
    repeat (1200) @(posedge clk_sys);
    chk({30'h0, lock_det_en, locked}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({irq, rd[30:0]}, 32'h8000_0003);
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk({irq, rd[30:0]}, 32'h0);
  endtask : lock_window

  // Calibration paused by each power-down bit, then completion and its interrupt
  task automatic calibration;
    int i;
    apb(1'b1, 8'h0c, 32'h0100_0000);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, cal_busy}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0100_0000);
    apb(1'b1, 8'h0c, 32'h0200_0000);
    chk({30'h0, sync_out_en, cal_clk_en}, 32'h2);
    repeat (100) @(posedge clk_sys);
    chk({31'h0, cal_busy}, 32'h1);
    apb(1'b1, 8'h0c, 32'h0400_0000);
    chk({30'h0, sync_out_en, cal_clk_en}, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    chk({30'h0, sync_out_en, cal_clk_en}, 32'h3);
    repeat (40) @(posedge clk_sys);
    chk({31'h0, cal_busy}, 32'h1);
    for (i = 0; i < 60 && cal_busy !== 1'b0; i++) @(posedge clk_sys);
    apb(1'b0, 8'h10, 32'h0);
    chk({cal_busy, irq, rd[29:0]}, 32'h4000_0004);
    apb(1'b1, 8'h14, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h18, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 8'h09, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : calibration

  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    loop_config();
    doubler_pump();
    apb(1'b1, 8'h14, 32'h7);
    lock_window();
    calibration();
    tally_and_finish();
  end

  // Watchdog, about twice the expected run
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
endmodule : clk_ctl_top_tb
